// [design/tweep_slave.sv]
// How it works
// R1: start is SDA falling while SCL high
// R2: stop is SDA rising while SCL high
// R3: writes commit only after a stop
// R4: master sends slave address first after start
// R5: top four address bits match type code
// R6: small variants compare three strap bits
// R7: large variant compares two strap bits
// R8: large variant takes address bit 8 from slave
// R9: lowest slave bit: zero write, one read
// R10: write-protect high blocks every write
// R11: receiver pulls SDA low on ninth clock
// R12: acknowledge a matching slave address
// R13: acknowledge word address and each data byte
// R14: acked read byte continues at next address
// R15: no ack: release bus, idle after stop
// R16: byte write stores at sent word address
// R17: small page keeps bits 6..3, eight bytes
// R18: middle page keeps bits 7..3, eight bytes
// R19: large page keeps bits 8..4, sixteen bytes
// R20: after reads counter points past last read
// R21: after writes counter stays at last written
// R22: random read loads address through dummy write
// R23: sample on SCL rise, drive after fall
// R24: programming cycle ends within ten milliseconds
// R25: page offset wraps inside its page
// R26: sequential read wraps to address zero
module tweep_slave
  import tweep_pkg::*;
#(
  parameter tweep_variant_t variant_p     = TWEEP_V256,
  parameter int unsigned    prog_cycles_p = TWEEP_TWR_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  input  wire logic wp_i,
  input  wire logic dev_sel_strap_0_i,
  input  wire logic dev_sel_strap_1_i,
  input  wire logic dev_sel_strap_2_i,
  output logic      busy_o
);

  tweep_state_t q;
  tweep_state_t d;

  logic [TWEEP_PIN_N-1:0] pins_s;
  logic                   scl_s;
  logic                   sda_s;
  logic                   wp_s;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_det;
  logic                   stop_det;
  logic                   addr_match;
  logic                   upper_half_select;
  logic                   rd_load;
  logic                   commit;
  logic [7:0]             rdata;
  logic [8:0]             page_base;
  logic [3:0]             pmask;

  logic [7:0] mem_q [0:TWEEP_MEM_WORDS-1];

  // word address wrap to the memory size of this variant
  function automatic logic [8:0] wrap_addr(input logic [8:0] a);
    unique case (variant_p)
      TWEEP_V128: wrap_addr = a & TWEEP_AMASK_128;
      TWEEP_V256: wrap_addr = a & TWEEP_AMASK_256;
      default:    wrap_addr = a & TWEEP_AMASK_512;
    endcase
  endfunction : wrap_addr

  // all pins cross into the clock domain before any logic sees them
  tweep_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .pins_i    ({dev_sel_strap_2_i, dev_sel_strap_1_i, dev_sel_strap_0_i,
                 wp_i, sda_i, scl_i}),
    .pins_o    (pins_s)
  );

  assign scl_s = pins_s[TWEEP_PIN_SCL];
  assign sda_s = pins_s[TWEEP_PIN_SDA];
  assign wp_s  = pins_s[TWEEP_PIN_WP];

  // bus events from the synchronised pins and last cycle's copies
  assign scl_rise  = scl_s & ~q.scl_p;
  assign scl_fall  = ~scl_s & q.scl_p;
  assign start_det = scl_s & q.scl_p & q.sda_p & ~sda_s; // R1
  assign stop_det  = scl_s & q.scl_p & ~q.sda_p & sda_s; // R2

  // page offset width and the fixed upper part of the page
  assign pmask     = (variant_p == TWEEP_V512) ? TWEEP_PMASK_16 : TWEEP_PMASK_8; // R17 R18 R19
  assign page_base = q.addr & ~{5'h00, pmask};
  assign rdata     = mem_q[q.addr];

  // slave address decode; the large variant frees its lowest strap
  assign upper_half_select = q.sh[1];
  always_comb begin
    if (variant_p == TWEEP_V512) begin
      addr_match = (q.sh[7:4] == TWEEP_DEV_TYPE) && // R5
                   (q.sh[3:2] == {pins_s[TWEEP_PIN_S2], pins_s[TWEEP_PIN_S1]}); // R7
    end else begin
      addr_match = (q.sh[7:4] == TWEEP_DEV_TYPE) && // R5
                   (q.sh[3:1] == {pins_s[TWEEP_PIN_S2], pins_s[TWEEP_PIN_S1],
                                  pins_s[TWEEP_PIN_S0]}); // R6
    end
  end

  // protocol engine: one next-state copy of the whole state
  always_comb begin
    d       = q;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    rd_load = 1'b0;
    commit  = 1'b0;
    if (q.st == TWEEP_PROG) begin
      // bus is ignored while programming, so masters see no acknowledge
      d.pcnt = q.pcnt + 1'b1;
      if (q.pcnt == TWEEP_PCNT_W'(prog_cycles_p - 1)) begin
        commit = 1'b1; // R24
        d.st   = TWEEP_IDLE;
        d.addr = page_base | {5'h00, q.last_off}; // R21
        d.mask = '0;
        d.pcnt = '0;
      end
    end else if (start_det) begin
      // a fresh start drops any unfinished write buffer
      d.st   = TWEEP_DEVADDR; // R1 R4
      d.cnt  = '0;
      d.oe   = 1'b0;
      d.mask = '0; // R3
    end else if (stop_det) begin
      d.oe   = 1'b0; // R15
      d.pcnt = '0;
      if ((q.mask != '0) && !wp_s &&
          (q.st == TWEEP_WDATA || q.st == TWEEP_ACK_WDATA)) begin
        d.st = TWEEP_PROG; // R3 R10 R16
      end else begin
        d.st   = TWEEP_IDLE; // R2
        d.mask = '0;
      end
    end else if (scl_rise) begin
      // incoming bits are taken on the rising edge
      if (q.st == TWEEP_DEVADDR || q.st == TWEEP_WADDR || q.st == TWEEP_WDATA) begin
        d.sh  = {q.sh[6:0], sda_s}; // R23
        d.cnt = q.cnt + 1'b1;
      end else if (q.st == TWEEP_RDATA) begin
        d.cnt = q.cnt + 1'b1;
      end else if (q.st == TWEEP_RACK) begin
        d.ack = ~sda_s; // R14
      end
    end else if (scl_fall) begin
      // outgoing changes happen only after a falling edge
      unique case (q.st)
        TWEEP_DEVADDR: begin
          if (q.cnt == TWEEP_BYTE_BITS) begin
            if (addr_match) begin
              d.oe = 1'b1; // R11 R12
              d.rw = q.sh[0]; // R9
              d.st = TWEEP_ACK_DEV;
              if (variant_p == TWEEP_V512) begin
                d.addr[8] = upper_half_select; // R8
              end
            end else begin
              d.st = TWEEP_WAIT_STOP;
            end
          end
        end
        TWEEP_ACK_DEV: begin
          d.cnt = '0;
          if (q.rw) begin
            rd_load = 1'b1; // R22
          end else begin
            d.oe = 1'b0; // R11
            d.st = TWEEP_WADDR;
          end
        end
        TWEEP_WADDR: begin
          if (q.cnt == TWEEP_BYTE_BITS) begin
            d.oe = 1'b1; // R13
            d.st = TWEEP_ACK_WADDR;
            if (variant_p == TWEEP_V512) begin
              d.addr = {q.addr[8], q.sh}; // R8
            end else begin
              d.addr = wrap_addr({1'b0, q.sh}); // R22
            end
            d.off = q.sh[3:0] & pmask;
          end
        end
        TWEEP_ACK_WADDR, TWEEP_ACK_WDATA: begin
          d.oe  = 1'b0;
          d.cnt = '0;
          d.st  = TWEEP_WDATA;
        end
        TWEEP_WDATA: begin
          if (q.cnt == TWEEP_BYTE_BITS) begin
            // held in the page buffer; memory is untouched until stop
            d.pbuf[q.off] = q.sh; // R3 R16
            d.mask[q.off] = 1'b1;
            d.last_off    = q.off;
            d.off         = (q.off + 1'b1) & pmask; // R25
            d.oe          = 1'b1; // R13
            d.st          = TWEEP_ACK_WDATA;
          end
        end
        TWEEP_RDATA: begin
          if (q.cnt == TWEEP_BYTE_BITS) begin
            d.oe  = 1'b0; // R11
            d.ack = 1'b0;
            d.st  = TWEEP_RACK;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe = ~q.sh[6]; // R23
          end
        end
        TWEEP_RACK: begin
          if (q.ack) begin
            rd_load = 1'b1; // R14
          end else begin
            d.st = TWEEP_WAIT_STOP; // R15
          end
        end
        default: begin
        end
      endcase
      // next read byte: fetch, drive its top bit, move the counter on
      if (rd_load) begin
        d.sh   = rdata;
        d.oe   = ~rdata[7];
        d.addr = wrap_addr(q.addr + 1'b1); // R20 R26
        d.cnt  = '0;
        d.st   = TWEEP_RDATA;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= TWEEP_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // buffered page lands in the array at the end of programming
  always_ff @(posedge ref_clk_i) begin
    if (commit) begin
      for (int i = 0; i < TWEEP_PAGE_MAX; i++) begin
        if (q.mask[i]) begin
          mem_q[page_base | 9'(i)] <= q.pbuf[i]; // R3 R16
        end
      end
    end
  end

  // open drain: only ever pull low
  assign sda_o    = 1'b0;
  assign sda_oe_o = q.oe;
  assign busy_o   = (q.st == TWEEP_PROG);

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_drive_after_fall: assert property ($rose(q.oe) |-> $past(scl_fall)) // R23
    else $error("sda drive began without a falling scl");

  a_idle_no_drive: assert property (q.st == TWEEP_IDLE |-> !q.oe) // R1
    else $error("sda driven while idle");

  a_dev_ack_low: assert property (
    (q.st == TWEEP_DEVADDR && scl_fall && q.cnt == TWEEP_BYTE_BITS && addr_match
     && !start_det && !stop_det)
    |=> q.oe && q.st == TWEEP_ACK_DEV) // R12
    else $error("matching slave address not acknowledged");

  a_data_ack_low: assert property (
    q.st == TWEEP_ACK_WDATA || q.st == TWEEP_ACK_WADDR |-> q.oe) // R13
    else $error("write byte not acknowledged");

  a_nack_release: assert property (
    (q.st == TWEEP_RACK && scl_fall && !q.ack && !start_det && !stop_det)
    |=> q.st == TWEEP_WAIT_STOP && !q.oe) // R15
    else $error("bus kept after missing acknowledge");

  a_stop_ends: assert property (
    (stop_det && q.st != TWEEP_PROG && q.mask == '0) |=> q.st == TWEEP_IDLE) // R2
    else $error("stop did not return to idle");

  a_read_advance: assert property (
    rd_load |=> q.addr == wrap_addr($past(q.addr) + 9'h001)) // R20
    else $error("read counter did not advance by one");

  a_page_fixed: assert property (
    (q.st == TWEEP_WDATA && scl_fall && q.cnt == TWEEP_BYTE_BITS && !start_det
     && !stop_det) |=> (q.addr == $past(q.addr)) && (q.off == (($past(q.off)
     + 4'h1) & pmask))) // R25
    else $error("page offset left its page");

  a_wp_blocks: assert property (
    (q.st != TWEEP_PROG) ##1 (q.st == TWEEP_PROG) |-> !$past(wp_s)) // R10
    else $error("programming started under write protect");

  a_prog_bound: assert property (
    q.st == TWEEP_PROG |-> q.pcnt < TWEEP_PCNT_W'(prog_cycles_p)) // R24
    else $error("programming ran past its limit");

endmodule : tweep_slave

// [inc/tweep_pkg.sv]
package tweep_pkg;

  // timing: clock period and the longest programming time
  localparam int unsigned TWEEP_CLK_PERIOD_NS = 100;
  localparam int unsigned TWEEP_TWR_MS        = 10;
  // longest time, so the count rounds down
  localparam int unsigned TWEEP_TWR_CYCLES    = (TWEEP_TWR_MS * 1000000) / TWEEP_CLK_PERIOD_NS;

  // device-type code compared against the top of the slave address (value arbitrary)
  localparam logic [3:0] TWEEP_DEV_TYPE = 4'h5;

  // bit counting and byte shape
  localparam logic [3:0] TWEEP_BYTE_BITS = 4'h8;
  localparam int unsigned TWEEP_MEM_WORDS = 512;
  localparam int unsigned TWEEP_PAGE_MAX  = 16;
  localparam int unsigned TWEEP_PCNT_W    = 17;

  // page offset masks: 8-byte and 16-byte pages
  localparam logic [3:0] TWEEP_PMASK_8  = 4'h7;
  localparam logic [3:0] TWEEP_PMASK_16 = 4'hF;

  // word address masks per memory size
  localparam logic [8:0] TWEEP_AMASK_128 = 9'h07F;
  localparam logic [8:0] TWEEP_AMASK_256 = 9'h0FF;
  localparam logic [8:0] TWEEP_AMASK_512 = 9'h1FF;

  // positions in the synchronised pin vector
  localparam int unsigned TWEEP_PIN_SCL = 0;
  localparam int unsigned TWEEP_PIN_SDA = 1;
  localparam int unsigned TWEEP_PIN_WP  = 2;
  localparam int unsigned TWEEP_PIN_S0  = 3;
  localparam int unsigned TWEEP_PIN_S1  = 4;
  localparam int unsigned TWEEP_PIN_S2  = 5;
  localparam int unsigned TWEEP_PIN_N   = 6;

  typedef enum logic [1:0] {
    TWEEP_V128 = 2'b00,
    TWEEP_V256 = 2'b01,
    TWEEP_V512 = 2'b10
  } tweep_variant_t;

  typedef enum logic [3:0] {
    TWEEP_IDLE      = 4'h0,
    TWEEP_DEVADDR   = 4'h1,
    TWEEP_ACK_DEV   = 4'h2,
    TWEEP_WADDR     = 4'h3,
    TWEEP_ACK_WADDR = 4'h4,
    TWEEP_WDATA     = 4'h5,
    TWEEP_ACK_WDATA = 4'h6,
    TWEEP_RDATA     = 4'h7,
    TWEEP_RACK      = 4'h8,
    TWEEP_WAIT_STOP = 4'h9,
    TWEEP_PROG      = 4'hA
  } tweep_fsm_t;

  typedef struct packed {
    tweep_fsm_t              st;
    logic                    scl_p;
    logic                    sda_p;
    logic [3:0]              cnt;
    logic [7:0]              sh;
    logic                    oe;
    logic                    rw;
    logic                    ack;
    logic [8:0]              addr;
    logic [3:0]              off;
    logic [3:0]              last_off;
    logic [15:0]             mask;
    logic [15:0][7:0]        pbuf;
    logic [TWEEP_PCNT_W-1:0] pcnt;
  } tweep_state_t;

  // everything idle, nothing buffered, bus released; the pin copies start
  // high like the idle bus, so the first cycle after reset shows no false edge
  localparam tweep_state_t TWEEP_STATE_RST = '{
    st:       TWEEP_IDLE,
    scl_p:    1'b1,
    sda_p:    1'b1,
    cnt:      4'h0,
    sh:       8'h00,
    oe:       1'b0,
    rw:       1'b0,
    ack:      1'b0,
    addr:     9'h000,
    off:      4'h0,
    last_off: 4'h0,
    mask:     16'h0000,
    pbuf:     '0,
    pcnt:     '0
  };

  typedef struct packed {
    logic [TWEEP_PIN_N-1:0] s1;
    logic [TWEEP_PIN_N-1:0] s2;
  } tweep_sync_t;

endpackage : tweep_pkg

// [design/tweep_sync.sv]
// two-stage synchroniser for every pin that the slave samples
module tweep_sync
  import tweep_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic [TWEEP_PIN_N-1:0] pins_i,
  output logic      [TWEEP_PIN_N-1:0] pins_o
);

  tweep_sync_t q;
  tweep_sync_t d;

  // first stage feeds only the second; bus idles high, so reset to high
  always_comb begin
    d    = q;
    d.s1 = pins_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign pins_o = q.s2;

endmodule : tweep_sync

// [test/tweep_master.sv]
// two-wire bus master: makes the serial clock, pulls data low only
module tweep_master (
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus: clock stands high, data left to the pull-up
  initial begin
    scl_o    = 1'h1;
    sda_oe_o = 1'h0;
  end

  // every move lands just after a system clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  // start, also used as a repeated start from a low clock
  task automatic start_c();
    tick(2);
    sda_oe_o = 1'h0;
    tick(2);
    scl_o = 1'h1;
    tick(4);
    sda_oe_o = 1'h1;
    tick(4);
    scl_o = 1'h0;
  endtask : start_c

  // stop leaves the clock high, so it stands still between frames
  task automatic stop_c();
    tick(2);
    sda_oe_o = 1'h1;
    tick(2);
    scl_o = 1'h1;
    tick(4);
    sda_oe_o = 1'h0;
    tick(4);
  endtask : stop_c

  // one bit: data moves only while the clock is low, read in mid-high
  task automatic bit_c(input logic drive, output logic seen);
    tick(2);
    sda_oe_o = ~drive;
    tick(2);
    scl_o = 1'h1;
    tick(2);
    seen = sda_i;
    tick(2);
    scl_o = 1'h0;
  endtask : bit_c

  // msb first, then release the line for the slave's ack
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(d[i], s);
    bit_c(1'h1, s);
    ack = ~s;
  endtask : wr_byte

  // released while the slave sends; ack low asks for the next word
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'h1, s);
      d = {d[6:0], s};
    end
    bit_c(~more, s);
  endtask : rd_byte
endmodule : tweep_master

// [test/tweep_slave_tb.sv]
module tweep_slave_tb
  import tweep_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // programming shortened so a probe byte still falls inside it
  localparam int unsigned PROG = 200;
  logic       ref_clk = 1'h0;
  logic       rst_n;
  logic       wp;
  logic       scl;
  logic       m_oe;
  logic       s_oe;
  logic       busy;
  logic       s_o;
  logic       oe_l;
  logic       oe_s;
  logic       busy_l;
  logic       busy_s;
  logic [2:0] strap = 3'h5;
  // slave address bits 3..1 that the bench sends, naming the part addressed
  logic [2:0] sel   = 3'h5;
  // open-drain bus with pull-up; the middle part's driven level is used as is
  wire        sda = ~(m_oe | oe_l | oe_s) & (s_oe ? s_o : 1'h1);
  int         fails = 0;
  int         checks_done = 0;
  int         cyc = 0;

  always #50 ref_clk = ~ref_clk;

  tweep_slave #(.variant_p(TWEEP_V256), .prog_cycles_p(PROG)) dut (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(s_o), .sda_oe_o(s_oe), .wp_i(wp), .dev_sel_strap_0_i(strap[0]),
    .dev_sel_strap_1_i(strap[1]), .dev_sel_strap_2_i(strap[2]), .busy_o(busy));

  // large part on the same bus: straps 2,1 = 0,1, lowest strap unused
  tweep_slave #(.variant_p(TWEEP_V512), .prog_cycles_p(PROG)) dut_l (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(oe_l), .wp_i(wp), .dev_sel_strap_0_i(1'h0),
    .dev_sel_strap_1_i(1'h1), .dev_sel_strap_2_i(1'h0), .busy_o(busy_l));

  // small part on the same bus: all straps low
  tweep_slave #(.variant_p(TWEEP_V128), .prog_cycles_p(PROG)) dut_s (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(oe_s), .wp_i(wp), .dev_sel_strap_0_i(1'h0),
    .dev_sel_strap_1_i(1'h0), .dev_sel_strap_2_i(1'h0), .busy_o(busy_s));

  tweep_master m (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  function automatic logic [7:0] dev(input logic rd);
    return {TWEEP_DEV_TYPE, sel, rd};
  endfunction : dev

  // bus helpers: byte with ack check, word fetch, address phases
  task automatic send(input logic [7:0] b, input logic e);
    logic a;
    m.wr_byte(b, a);
    chk("ack", {7'h00, e}, {7'h00, a});
  endtask : send

  task automatic get(input logic [7:0] e, input logic more);
    logic [7:0] d;
    m.rd_byte(more, d);
    chk("rdata", e, d);
  endtask : get

  task automatic addr_w(input logic [7:0] a);
    m.start_c();
    send(dev(1'h0), 1'h1);
    send(a, 1'h1);
  endtask : addr_w

  task automatic rnd(input logic [7:0] a);
    addr_w(a);
    m.start_c();
    send(dev(1'h1), 1'h1);
  endtask : rnd

  // bounded wait for programming to finish
  task automatic wait_idle();
    int n;
    n = 0;
    while ((busy | busy_l | busy_s) !== 1'h0 && n < PROG + 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("busy", 8'h00, {5'h00, busy_s, busy_l, busy});
  endtask : wait_idle

  // one flipped bit in type code or straps gets no ack
  task automatic t_select();
    for (int i = 1; i < 8; i++) begin
      m.start_c();
      send(dev(1'h1) ^ (8'h01 << i), 1'h0);
      m.stop_c();
    end
    // moved straps must move the address that is answered
    strap = 3'h6;
    sel   = 3'h6;
    m.start_c();
    send(dev(1'h0), 1'h1);
    m.stop_c();
    strap = 3'h5;
    sel   = 3'h5;
  endtask : t_select

  // page write from offset 5 wraps inside the page at 0x18
  task automatic t_page();
    addr_w(8'h1D);
    for (int i = 0; i < 8; i++) send(8'h10 + i[7:0], 1'h1);
    m.stop_c();
    chk("busy", 8'h01, {7'h00, busy});
    m.start_c();
    send(dev(1'h1), 1'h0);
    m.stop_c();
    wait_idle();
    m.start_c();
    send(dev(1'h1), 1'h1);
    get(8'h17, 1'h0);
    m.stop_c();
    m.start_c();
    send(dev(1'h1), 1'h1);
    get(8'h10, 1'h1);
    get(8'h11, 1'h0);
    m.stop_c();
    rnd(8'h18);
    for (int i = 0; i < 5; i++) get(8'h13 + i[7:0], i < 4);
    m.stop_c();
  endtask : t_page

  // protected write is acked but never programmed
  task automatic t_wp();
    wp = 1'h1;
    addr_w(8'h18);
    send(8'h55, 1'h1);
    m.stop_c();
    chk("busy", 8'h00, {7'h00, busy});
    wp = 1'h0;
    rnd(8'h18);
    get(8'h13, 1'h0);
    m.stop_c();
  endtask : t_wp

  // repeated start drops a write that never saw its stop
  task automatic t_abort();
    addr_w(8'h19);
    send(8'h66, 1'h1);
    rnd(8'h19);
    get(8'h14, 1'h0);
    m.stop_c();
    chk("busy", 8'h00, {7'h00, busy});
  endtask : t_abort

  // byte writes at both ends, then a read that crosses the top
  task automatic t_wrap();
    addr_w(8'hFF);
    send(8'hC3, 1'h1);
    m.stop_c();
    wait_idle();
    addr_w(8'h00);
    send(8'h3C, 1'h1);
    m.stop_c();
    wait_idle();
    rnd(8'hFF);
    get(8'hC3, 1'h1);
    get(8'h3C, 1'h0);
    m.stop_c();
  endtask : t_wrap

  // large part: page-select bit picks the half, sixteen-byte page wraps
  task automatic t_large();
    sel = 3'h3;
    addr_w(8'hF3);
    for (int i = 0; i < 16; i++) send(8'h40 + i[7:0], 1'h1);
    m.stop_c();
    wait_idle();
    m.start_c();
    send(dev(1'h1), 1'h1);
    get(8'h4F, 1'h0);
    m.stop_c();
    sel = 3'h2;
    addr_w(8'hF3);
    send(8'h99, 1'h1);
    m.stop_c();
    wait_idle();
    sel = 3'h3;
    rnd(8'hF0);
    get(8'h4D, 1'h1);
    get(8'h4E, 1'h1);
    get(8'h4F, 1'h1);
    get(8'h40, 1'h0);
    m.stop_c();
    sel = 3'h2;
    rnd(8'hF3);
    get(8'h99, 1'h0);
    m.stop_c();
  endtask : t_large

  // small part: word address bit 7 ignored, eight-byte page wraps at 0x78
  task automatic t_small();
    sel = 3'h0;
    addr_w(8'hFF);
    send(8'hA1, 1'h1);
    send(8'hA2, 1'h1);
    m.stop_c();
    wait_idle();
    rnd(8'h78);
    get(8'hA2, 1'h0);
    m.stop_c();
    rnd(8'hFF);
    get(8'hA1, 1'h0);
    m.stop_c();
    sel = 3'h5;
  endtask : t_small

  // a hang is cut short well above the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  // reset, let the synchroniser refill, then the scenarios
  initial begin
    rst_n = 1'h0;
    wp = 1'h0;
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'h1;
    repeat (4) @(posedge ref_clk);
    #1;
    t_select();
    t_page();
    t_wp();
    t_abort();
    t_wrap();
    t_large();
    t_small();
    summarize();
  end
endmodule : tweep_slave_tb
